// ==== cks_pkg.sv ====
// Package for the system clock source selector.
// Holds register offsets, field positions, reset values, source codes and counts.
// Assumes a 100 MHz system clock and a 32-bit AHB-Lite register port.
package cks_pkg;

   // Clock and bus figures.
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam logic [27:0] CLK_HZ = 28'h5F5_E100;
   localparam int unsigned AW = 4;

   // Register byte offsets.
   localparam logic [AW-1:0] OFS_OSC_CTRL = 4'h0;
   localparam logic [AW-1:0] OFS_OSC_STAT = 4'h4;
   localparam logic [AW-1:0] OFS_TMR_CTRL = 4'h8;

   // Oscillator control field positions and reset value.
   localparam int unsigned POS_PLL = 7;
   localparam int unsigned POS_FREQ = 3;
   localparam int unsigned POS_UNIMPL = 2;
   localparam int unsigned POS_SEL = 0;
   localparam logic [7:0] OSC_CTRL_RST = 8'h38;
   localparam logic [7:0] OSC_CTRL_WMASK = 8'hFB;

   // Status and timer control field positions.
   localparam int unsigned POS_STARTUP_TIMEOUT_STATUS = 0;
   localparam int unsigned POS_PLL_ACT = 1;
   localparam int unsigned POS_PEND = 2;
   localparam int unsigned POS_FAIL = 3;
   localparam int unsigned POS_ACT_SRC = 4;
   localparam int unsigned POS_SEC_RDY = 7;
   localparam int unsigned POS_SEC_EN = 3;

   // Counts of oscillator edges; FAIL_CYCLES counts system clock cycles.
   localparam logic [11:0] OST_EDGES = 12'h400;
   localparam logic [11:0] SEC_READY_EDGES = 12'h100;
   localparam logic [11:0] STAB_TICKS = 12'h008;
   localparam logic [11:0] FAIL_CYCLES = 12'hFA0;

   // Configuration oscillator codes.
   typedef enum logic [2:0] {
      CFG_LP = 3'h0, CFG_XT = 3'h1, CFG_HS = 3'h2, CFG_RC = 3'h3,
      CFG_INT = 3'h4, CFG_EC_LO = 3'h5, CFG_EC_MID = 3'h6, CFG_EC_HI = 3'h7
   } cks_cfg_e;

   // Running clock source.
   typedef enum logic [1:0] {
      SRC_EXT = 2'b00, SRC_SEC = 2'b01, SRC_INT = 2'b10
   } cks_src_e;

   // Internal oscillator used for a frequency code.
   typedef enum logic [1:0] {
      OSC_LF = 2'b00, OSC_MF = 2'b01, OSC_HF = 2'b10
   } cks_osc_e;

   // Frequency in Hz of the internal block for a select code.
   function automatic logic [27:0] cks_freq_hz(input logic [3:0] code, input logic pll);
      case (code)
         4'h0, 4'h1: cks_freq_hz = 28'h000_7918;
         4'h2, 4'h3: cks_freq_hz = 28'h000_7A12;
         4'h4: cks_freq_hz = 28'h000_F424;
         4'h5, 4'h8: cks_freq_hz = 28'h001_E848;
         4'h6, 4'h9: cks_freq_hz = 28'h003_D090;
         4'h7, 4'hA: cks_freq_hz = 28'h007_A120;
         4'hB: cks_freq_hz = 28'h00F_4240;
         4'hC: cks_freq_hz = 28'h01E_8480;
         4'hD: cks_freq_hz = 28'h03D_0900;
         4'hE: cks_freq_hz = pll ? 28'h1E8_4800 : 28'h07A_1200;
         default: cks_freq_hz = 28'h0F4_2400;
      endcase
   endfunction : cks_freq_hz

   // Internal oscillator that serves a frequency code.
   function automatic cks_osc_e cks_osc_of(input logic [3:0] code);
      if (code[3:1] == 3'b000) begin
         cks_osc_of = OSC_LF;
      end else if (code == 4'h2 || code[3:2] == 2'b01) begin
         cks_osc_of = OSC_MF;
      end else begin
         cks_osc_of = OSC_HF;
      end
   endfunction : cks_osc_of

endpackage : cks_pkg

// ==== cks_clock_select.sv ====
// System clock source selector with its oscillator control registers.
// Assumes oscillator pins are asynchronous levels and configuration inputs are static.
// Behaviour
// - Internal block yields 16M, 500k, 31k sources.
// - Configuration field picks default clock after reset.
// - External clock codes 111, 110, 101.
// - External clock mode bypasses the start-up timer.
// - Stopped external clock halts, state preserved.
// - External clock mode frees second oscillator pin.
// - Selected clock drives core and peripherals.
// - Select 00 uses configured oscillator.
// - Select 01 uses secondary timer oscillator.
// - Select 1x uses internal block frequency.
// - Every reset clears the select field.
// - Automatic switches leave select field; status shows.
// - New clock stabilises before it is used.
// - Start-up status shows external versus internal source.
// - Timer control bit enables secondary oscillator.
// - Configuration PLL overrides software PLL enable.
// - Frequency field decodes to low, medium, high.
// - Reset gives 500 kHz medium, PLL off.
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
module cks_clock_select (
   // Clock and reset.
   input wire logic CLK,
   input wire logic RSTN,
   // AHB-Lite register port.
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Configuration word.
   input wire logic [2:0] CFG_OSC_SELECT,
   input wire logic CFG_PLL_ON,
   input wire logic CFG_TWO_SPEED,
   input wire logic CFG_FAILSAFE,
   input wire logic CFG_CLKOUT_EN,
   // Oscillator pins.
   input wire logic EXT_CLK_IN,
   input wire logic SEC_OSC_IN,
   // Second oscillator pin as general I/O.
   input wire logic GPIO_O,
   input wire logic GPIO_OE,
   output logic SECOND_OSC_PIN_O,
   output logic SECOND_OSC_PIN_OE,
   // Clock enables and state.
   output logic CORE_CLK_EN,
   output logic PERIPH_CLK_EN,
   output logic SECONDARY_OSC_ENABLE,
   output logic PLL_ACTIVE,
   output cks_pkg::cks_src_e ACTIVE_SRC,
   output cks_pkg::cks_osc_e INT_OSC_SRC
);
   import cks_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset release and pin synchronisers.
   logic rst_s1_reg, rst_n;
   logic [2:0] ext_sync_reg, sec_sync_reg;
   logic ext_tick, sec_tick;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_s1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n <= rst_s1_reg;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ext_sync_reg <= 3'b000;
         sec_sync_reg <= 3'b000;
      end else begin
         ext_sync_reg <= {ext_sync_reg[1:0], EXT_CLK_IN};
         sec_sync_reg <= {sec_sync_reg[1:0], SEC_OSC_IN};
      end
   end

   // Only the later stages feed the edge detectors, never the first.
   assign ext_tick = ext_sync_reg[1] & ~ext_sync_reg[2];
   assign sec_tick = sec_sync_reg[1] & ~sec_sync_reg[2];

   ////////////////////////////////////////////////////////////////////////////////
   // Registers and AHB-Lite slave.
   logic [7:0] osc_ctrl_reg;
   logic sec_en_reg;
   logic ph_valid_reg, ph_write_reg, rd_pend_reg;
   logic [AW-1:0] ph_addr_reg;
   logic [31:0] hrdata_reg;
   logic [7:0] status;
   logic [1:0] sel;
   logic [3:0] freq_sel;
   logic accept, wr_ctrl;

   assign accept = HSEL & HTRANS[1] & HREADY;
   assign wr_ctrl = ph_valid_reg & ph_write_reg & (ph_addr_reg == OFS_OSC_CTRL);
   assign sel = osc_ctrl_reg[POS_SEL +: 2];
   assign freq_sel = osc_ctrl_reg[POS_FREQ +: 4];

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ph_valid_reg <= 1'b0;
         ph_write_reg <= 1'b0;
         ph_addr_reg <= '0;
         rd_pend_reg <= 1'b0;
      end else begin
         if (HREADYOUT) begin
            ph_valid_reg <= accept;
            ph_write_reg <= HWRITE;
            ph_addr_reg <= HADDR[AW-1:0];
         end
         rd_pend_reg <= accept & ~HWRITE & HREADYOUT;
      end
   end

   // Reads take one wait state so a read right behind a write sees the new value.
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (rd_pend_reg) begin
         case (ph_addr_reg)
            OFS_OSC_CTRL: hrdata_reg <= {24'h00_0000, osc_ctrl_reg};
            OFS_OSC_STAT: hrdata_reg <= {24'h00_0000, status};
            OFS_TMR_CTRL: hrdata_reg <= {24'h00_0000, 4'h0, sec_en_reg, 3'h0};
            default: hrdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         osc_ctrl_reg <= OSC_CTRL_RST;
      end else if (wr_ctrl) begin
         osc_ctrl_reg <= HWDATA[7:0] & OSC_CTRL_WMASK;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         sec_en_reg <= 1'b0;
      end else if (ph_valid_reg && ph_write_reg && ph_addr_reg == OFS_TMR_CTRL) begin
         sec_en_reg <= HWDATA[POS_SEC_EN];
      end
   end

   assign HREADYOUT = ~rd_pend_reg;
   assign HRDATA = hrdata_reg;
   assign HRESP = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////
   // Primary oscillator: start-up timer and fail-safe watch.
   logic ec_mode, crystal_mode, cfg_internal;
   logic [11:0] ost_cnt_reg, fail_cnt_reg;
   logic ost_done, fail_reg;
   cks_src_e active_reg;

   assign ec_mode = CFG_OSC_SELECT[2] & (CFG_OSC_SELECT[1:0] != 2'b00);
   assign crystal_mode = (CFG_OSC_SELECT[2:1] == 2'b00) | (CFG_OSC_SELECT == CFG_HS);
   assign cfg_internal = (CFG_OSC_SELECT == CFG_INT);

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ost_cnt_reg <= 12'h000;
      end else if (crystal_mode && ext_tick && ost_cnt_reg != OST_EDGES) begin
         ost_cnt_reg <= ost_cnt_reg + 12'h001;
      end
   end

   // Only crystals wait for the timer; an external clock runs at once.
   assign ost_done = ~crystal_mode | (ost_cnt_reg == OST_EDGES);

   // A dead primary clock while running from it moves the system to internal.
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         fail_cnt_reg <= 12'h000;
         fail_reg <= 1'b0;
      end else if (ext_tick || active_reg != SRC_EXT || !CFG_FAILSAFE || cfg_internal) begin
         fail_cnt_reg <= 12'h000;
      end else if (fail_cnt_reg == FAIL_CYCLES) begin
         fail_reg <= 1'b1;
      end else begin
         fail_cnt_reg <= fail_cnt_reg + 12'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Secondary oscillator enable and ready.
   logic [11:0] sec_cnt_reg;
   logic sec_ready;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         sec_cnt_reg <= 12'h000;
      end else if (!sec_en_reg) begin
         sec_cnt_reg <= 12'h000;
      end else if (sec_tick && sec_cnt_reg != SEC_READY_EDGES) begin
         sec_cnt_reg <= sec_cnt_reg + 12'h001;
      end
   end

   // Software must see this set before choosing the secondary source.
   assign sec_ready = sec_en_reg & (sec_cnt_reg == SEC_READY_EDGES);

   ////////////////////////////////////////////////////////////////////////////////
   // Internal oscillator block as a fractional divider of the system clock.
   logic [27:0] int_acc_reg, int_inc, int_sum;
   logic int_tick;

   assign PLL_ACTIVE = CFG_PLL_ON | osc_ctrl_reg[POS_PLL];
   assign int_inc = cks_freq_hz(freq_sel, PLL_ACTIVE);
   assign int_sum = int_acc_reg + int_inc;
   assign int_tick = (int_sum >= CLK_HZ);

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         int_acc_reg <= 28'h000_0000;
      end else if (int_tick) begin
         int_acc_reg <= int_sum - CLK_HZ;
      end else begin
         int_acc_reg <= int_sum;
      end
   end

   assign INT_OSC_SRC = cks_osc_of(freq_sel);

   ////////////////////////////////////////////////////////////////////////////////
   // Source request and switching.
   cks_src_e req_src, tgt_src;
   logic [11:0] stab_cnt_reg;
   logic tgt_tick, act_tick, pending;

   always_comb begin
      case (sel)
         2'b00: req_src = cfg_internal ? SRC_INT : SRC_EXT;
         2'b01: req_src = SRC_SEC;
         default: req_src = SRC_INT;
      endcase
      tgt_src = req_src;
      // Automatic fall-backs change only the running source, never the field.
      if (req_src == SRC_EXT && (fail_reg || (CFG_TWO_SPEED && !ost_done))) begin
         tgt_src = SRC_INT;
      end
   end

   function automatic logic src_tick(input cks_src_e s, input logic e, input logic c,
                                     input logic i);
      case (s)
         SRC_EXT: src_tick = e;
         SRC_SEC: src_tick = c;
         default: src_tick = i;
      endcase
   endfunction : src_tick

   // The primary only ticks while its pin toggles, so a stopped clock freezes all.
   assign tgt_tick = src_tick(tgt_src, ext_tick & ost_done, sec_tick, int_tick);
   assign act_tick = src_tick(active_reg, ext_tick & ost_done, sec_tick, int_tick);
   assign pending = (tgt_src != active_reg);

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         stab_cnt_reg <= 12'h000;
      end else if (!pending) begin
         stab_cnt_reg <= 12'h000;
      end else if (tgt_tick && stab_cnt_reg != STAB_TICKS) begin
         stab_cnt_reg <= stab_cnt_reg + 12'h001;
      end
   end

   // Switch only between enable pulses, so no pulse is ever cut short.
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         active_reg <= SRC_INT;
      end else if (pending && stab_cnt_reg == STAB_TICKS && !act_tick) begin
         active_reg <= tgt_src;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Clock enables, status and second pin.
   logic sys_en_reg, pin2_o_reg, pin2_oe_reg, clkout_reg;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         sys_en_reg <= 1'b0;
         clkout_reg <= 1'b0;
      end else begin
         sys_en_reg <= act_tick;
         clkout_reg <= clkout_reg ^ act_tick;
      end
   end

   assign CORE_CLK_EN = sys_en_reg;
   assign PERIPH_CLK_EN = sys_en_reg;

   // Running from the configured primary sets the start-up status bit.
   assign status = {sec_ready, 1'b0, active_reg, fail_reg, pending, PLL_ACTIVE,
                    (active_reg == SRC_EXT) & ost_done};

   // In crystal modes the oscillator owns the pin, so it is never driven.
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pin2_o_reg <= 1'b0;
         pin2_oe_reg <= 1'b0;
      end else if (!crystal_mode && CFG_CLKOUT_EN) begin
         pin2_o_reg <= clkout_reg;
         pin2_oe_reg <= 1'b1;
      end else begin
         pin2_o_reg <= GPIO_O;
         pin2_oe_reg <= GPIO_OE & ~crystal_mode;
      end
   end

   assign SECOND_OSC_PIN_O = pin2_o_reg;
   assign SECOND_OSC_PIN_OE = pin2_oe_reg;
   assign SECONDARY_OSC_ENABLE = sec_en_reg;
   assign ACTIVE_SRC = active_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   sel_reset_a: assert property (@(posedge CLK) $rose(rst_n) |-> osc_ctrl_reg == 8'h38)
      else $error("Control register not at reset value.");
   unimpl_zero_a: assert property (@(posedge CLK) disable iff (!rst_n)
      $past(rd_pend_reg) && ph_addr_reg == OFS_OSC_CTRL |-> hrdata_reg[POS_UNIMPL] == 1'b0)
      else $error("Unimplemented bit read as one.");
   pll_force_a: assert property (@(posedge CLK) disable iff (!rst_n)
      CFG_PLL_ON |-> PLL_ACTIVE)
      else $error("PLL off while forced on.");
   pll_soft_a: assert property (@(posedge CLK) disable iff (!rst_n)
      !CFG_PLL_ON |-> PLL_ACTIVE == osc_ctrl_reg[POS_PLL])
      else $error("PLL enable does not follow the software bit.");
   ec_bypass_a: assert property (@(posedge CLK) disable iff (!rst_n)
      ec_mode |-> ost_done && !(stab_cnt_reg == 12'h000 && pending && tgt_src == SRC_INT
      && sel == 2'b00 && !fail_reg))
      else $error("External clock waited on start-up timer.");
   sel_hold_a: assert property (@(posedge CLK) disable iff (!rst_n)
      $changed(osc_ctrl_reg) |-> $past(wr_ctrl))
      else $error("Select field changed without a write.");
   auto_switch_a: assert property (@(posedge CLK) disable iff (!rst_n)
      fail_reg && sel == 2'b00 |-> tgt_src == SRC_INT)
      else $error("Fail-safe trip did not move the system to internal.");
   clk_source_a: assert property (@(posedge CLK) disable iff (!rst_n)
      sys_en_reg |-> $past(act_tick) && CORE_CLK_EN == PERIPH_CLK_EN)
      else $error("Clock enable not from active source.");
   switch_stable_a: assert property (@(posedge CLK) disable iff (!rst_n)
      $changed(active_reg) |-> $past(stab_cnt_reg) == 12'h008 && !$past(act_tick))
      else $error("Switched before new clock stabilised.");
   sec_ready_a: assert property (@(posedge CLK) disable iff (!rst_n)
      status[POS_SEC_RDY] |-> sec_en_reg ##0 $past(sec_en_reg))
      else $error("Secondary ready without enable.");
   sec_select_a: assert property (@(posedge CLK) disable iff (!rst_n)
      (sel == 2'b01 && !pending) |-> active_reg == SRC_SEC)
      else $error("Select 01 not running from secondary.");
   int_select_a: assert property (@(posedge CLK) disable iff (!rst_n)
      (sel[1] && !pending) |-> active_reg == SRC_INT)
      else $error("Select 1x not running from internal block.");
   pin_free_a: assert property (@(posedge CLK) disable iff (!rst_n)
      crystal_mode |=> !SECOND_OSC_PIN_OE)
      else $error("Oscillator pin driven in crystal mode.");
   ost_status_a: assert property (@(posedge CLK) disable iff (!rst_n)
      crystal_mode && !ost_done |-> !status[POS_STARTUP_TIMEOUT_STATUS])
      else $error("Start-up status set before the timer expired.");

endmodule : cks_clock_select

// ==== testbench.sv ====
// Self-checking testbench for the system clock source selector.
// Assumes the selector is the only AHB-Lite slave, so its ready output is the bus ready.
// Oscillator pins are toggled from counters on CLK; they stand still while stopped.
`timescale 1ns/1ns
module testbench;
   import cks_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////
   logic CLK = 1'b0;
   logic RSTN = 1'b0;
   logic HSEL = 1'b0;
   logic [31:0] HADDR = 32'h0000_0000;
   logic [1:0] HTRANS = 2'h0;
   logic HWRITE = 1'b0;
   logic [2:0] HSIZE = 3'h2;
   logic [31:0] HWDATA = 32'h0000_0000;
   wire logic HREADY;
   logic [31:0] HRDATA;
   logic HREADYOUT, HRESP;
   logic [2:0] CFG_OSC_SELECT = 3'h7;
   logic CFG_PLL_ON = 1'b0;
   logic CFG_TWO_SPEED = 1'b0;
   logic CFG_FAILSAFE = 1'b0;
   logic CFG_CLKOUT_EN = 1'b0;
   logic EXT_CLK_IN = 1'b0;
   logic SEC_OSC_IN = 1'b0;
   logic GPIO_O = 1'b0;
   logic GPIO_OE = 1'b1;
   logic SECOND_OSC_PIN_O, SECOND_OSC_PIN_OE, CORE_CLK_EN, PERIPH_CLK_EN;
   logic SECONDARY_OSC_ENABLE, PLL_ACTIVE;
   cks_src_e ACTIVE_SRC;
   cks_osc_e INT_OSC_SRC;
   logic ext_run = 1'b1;
   logic sec_run = 1'b0;
   logic [1:0] div = 2'h0;
   logic prev_en = 1'b0;
   int num_errors = 0;
   int n_tests = 0;
   int pulses = 0;
   int seed = 32'h4449;
   logic [31:0] r, v;
   logic [2:0] cfgs [4] = '{3'h4, 3'h5, 3'h6, 3'h7};

   cks_clock_select DUT (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CFG_OSC_SELECT(CFG_OSC_SELECT),
      .CFG_PLL_ON(CFG_PLL_ON), .CFG_TWO_SPEED(CFG_TWO_SPEED), .CFG_FAILSAFE(CFG_FAILSAFE),
      .CFG_CLKOUT_EN(CFG_CLKOUT_EN), .EXT_CLK_IN(EXT_CLK_IN), .SEC_OSC_IN(SEC_OSC_IN),
      .GPIO_O(GPIO_O), .GPIO_OE(GPIO_OE),
      .SECOND_OSC_PIN_O(SECOND_OSC_PIN_O), .SECOND_OSC_PIN_OE(SECOND_OSC_PIN_OE),
      .CORE_CLK_EN(CORE_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
      .SECONDARY_OSC_ENABLE(SECONDARY_OSC_ENABLE), .PLL_ACTIVE(PLL_ACTIVE),
      .ACTIVE_SRC(ACTIVE_SRC), .INT_OSC_SRC(INT_OSC_SRC));

   assign HREADY = HREADYOUT;

   always #5 CLK = ~CLK;

   // Both oscillators run at a quarter of CLK, slow enough for the three-stage synchronisers.
   always @(posedge CLK) begin
      div <= div + 2'h1;
      if (ext_run && div[0]) EXT_CLK_IN <= ~EXT_CLK_IN;
      if (sec_run && div[0]) SEC_OSC_IN <= ~SEC_OSC_IN;
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim;
      $display("mismatches %0d, comparisons %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim

   // Sampling at the falling edge keeps the bench clear of races with the slave's flops.
   task automatic wait_ready;
      int n;
      n = 0;
      @(negedge CLK);
      while (HREADY !== 1'b1) begin
         n++;
         if (n > 50) begin
            num_errors++;
            end_sim();
         end
         @(negedge CLK);
      end
   endtask : wait_ready

   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      HADDR <= a;
      HWRITE <= wr;
      wait_ready();
      @(posedge CLK);
      HSEL <= 1'b0;
      HTRANS <= 2'b00;
      HWDATA <= wd;
      wait_ready();
      rd = HRDATA;
      @(posedge CLK);
   endtask : ahb

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      ahb(1'b0, a, 32'h0000_0000, d);
   endtask : rd

   task automatic wait_src(input cks_src_e want, input int bound);
      int n;
      n = 0;
      @(negedge CLK);
      while (ACTIVE_SRC !== want && n < bound) begin
         @(negedge CLK);
         n++;
      end
      check(32'(ACTIVE_SRC), 32'(want));
      @(posedge CLK);
   endtask : wait_src

   task automatic do_reset(input logic [2:0] cfg, input logic pll);
      @(posedge CLK);
      RSTN <= 1'b0;
      CFG_OSC_SELECT <= cfg;
      CFG_PLL_ON <= pll;
      repeat (2) @(posedge CLK);
      RSTN <= 1'b1;
      repeat (3) @(posedge CLK);
   endtask : do_reset

   function automatic cks_osc_e exp_osc(input logic [3:0] c);
      if (c < 4'h2) return OSC_LF;
      if (c == 4'h2 || (c >= 4'h4 && c <= 4'h7)) return OSC_MF;
      return OSC_HF;
   endfunction : exp_osc

   ////////////////////////////////////////////////////////////////////////////////////////
   // Enables must pair up and never merge two ticks into one long pulse.
   always @(negedge CLK) begin
      if (RSTN === 1'b1) begin
         check(32'(CORE_CLK_EN), 32'(PERIPH_CLK_EN));
         check(32'(prev_en & CORE_CLK_EN), 32'h0000_0000);
         if (CORE_CLK_EN === 1'b1) pulses++;
      end
      prev_en = CORE_CLK_EN;
   end

   initial begin
      repeat (90000) @(posedge CLK);
      num_errors++;
      end_sim();
   end

   initial begin
      for (int i = 0; i < 4; i++) begin
         do_reset(cfgs[i], ~i[0]);
         rd(32'(OFS_OSC_CTRL), r);
         check(r, 32'h0000_0038);
         rd(32'(OFS_TMR_CTRL), r);
         check(r, 32'h0000_0000);
         check(32'(INT_OSC_SRC), 32'(OSC_MF));
         check(32'(PLL_ACTIVE), {31'h0, ~i[0]});
         // External codes must switch well inside the 1024-edge timer span.
         wait_src(cfgs[i] == 3'h4 ? SRC_INT : SRC_EXT, 200);
         rd(32'(OFS_OSC_STAT), r);
         v = {24'h0, 2'b00, (cfgs[i] == 3'h4 ? 2'b10 : 2'b00), 2'b00, ~i[0], cfgs[i] != 3'h4};
         check(r, v);
         GPIO_O <= 1'($random(seed));
         repeat (3) @(posedge CLK);
         check(32'(SECOND_OSC_PIN_OE), 32'(GPIO_OE));
         check(32'(SECOND_OSC_PIN_O), 32'(GPIO_O));
      end
      // A stopped external clock halts all enable pulses; after restart they resume from the external source.
      ext_run <= 1'b0;
      repeat (10) @(posedge CLK);
      pulses = 0;
      repeat (40) @(posedge CLK);
      check(32'(pulses), 32'h0000_0000);
      ext_run <= 1'b1;
      repeat (40) @(posedge CLK);
      check(32'(pulses >= 8), 32'h0000_0001);
      check(32'(ACTIVE_SRC), 32'(SRC_EXT));
      // Clock output mode drives the second pin even with the general enable off.
      CFG_CLKOUT_EN <= 1'b1;
      GPIO_OE <= 1'b0;
      repeat (3) @(posedge CLK);
      check(32'(SECOND_OSC_PIN_OE), 32'h0000_0001);
      CFG_CLKOUT_EN <= 1'b0;
      GPIO_OE <= 1'b1;
      wr(32'(OFS_OSC_CTRL), 32'hFFFF_FFFF);
      rd(32'(OFS_OSC_CTRL), r);
      check(r, 32'h0000_00FB);
      check(32'(PLL_ACTIVE), 32'h0000_0001);
      wait_src(SRC_INT, 300);
      rd(32'(OFS_OSC_STAT), r);
      check(r, 32'h0000_0022);
      for (int c = 0; c < 16; c++) begin
         r = $random(seed);
         v = {24'h0, r[0], 4'(c), r[1], 2'b10};
         wr(32'(OFS_OSC_CTRL), v);
         rd(32'(OFS_OSC_CTRL), r);
         check(r, v & 32'h0000_00FB);
         check(32'(INT_OSC_SRC), 32'(exp_osc(4'(c))));
         check(32'(PLL_ACTIVE), 32'(v[7]));
      end
      wr(32'h0000_000C, $random(seed));
      rd(32'h0000_000C, r);
      check(r, 32'h0000_0000);
      check(32'(HRESP), 32'h0000_0000);
      wr(32'(OFS_TMR_CTRL), 32'h0000_0008);
      @(negedge CLK);
      check(32'(SECONDARY_OSC_ENABLE), 32'h0000_0001);
      sec_run <= 1'b1;
      r = 32'h0000_0000;
      for (int n = 0; n < 40 && r[POS_SEC_RDY] !== 1'b1; n++) begin
         repeat (50) @(posedge CLK);
         rd(32'(OFS_OSC_STAT), r);
      end
      check(32'(r[POS_SEC_RDY]), 32'h0000_0001);
      wr(32'(OFS_OSC_CTRL), 32'h0000_0039);
      wait_src(SRC_SEC, 300);
      rd(32'(OFS_OSC_STAT), r);
      check(r, 32'h0000_0090);
      wr(32'(OFS_OSC_CTRL), 32'h0000_0038);
      wait_src(SRC_EXT, 300);
      rd(32'(OFS_OSC_STAT), r);
      check(r, 32'h0000_0081);
      // Reset in mid-run with the secondary oscillator selected.
      wr(32'(OFS_OSC_CTRL), 32'h0000_0039);
      CFG_FAILSAFE <= 1'b1;
      do_reset(3'h7, 1'b0);
      rd(32'(OFS_OSC_CTRL), r);
      check(r, 32'h0000_0038);
      check(32'(SECONDARY_OSC_ENABLE), 32'h0000_0000);
      // A dead primary trips the fail-safe: internal runs, the select field stays put.
      wait_src(SRC_EXT, 300);
      ext_run <= 1'b0;
      wait_src(SRC_INT, 8000);
      rd(32'(OFS_OSC_CTRL), r);
      check(r, 32'h0000_0038);
      rd(32'(OFS_OSC_STAT), r);
      check(r, 32'h0000_0028);
      // A crystal with two-speed start-up runs internal until the timer expires.
      ext_run <= 1'b1;
      CFG_TWO_SPEED <= 1'b1;
      do_reset(3'h2, 1'b0);
      rd(32'(OFS_OSC_STAT), r);
      check(r, 32'h0000_0020);
      check(32'(SECOND_OSC_PIN_OE), 32'h0000_0000);
      wait_src(SRC_EXT, 6000);
      rd(32'(OFS_OSC_STAT), r);
      check(r, 32'h0000_0001);
      end_sim();
   end

endmodule : testbench
